// File: verilog/pt_timer.sv
// paired 16-bit timers, cascadable to 32 bits, with AHB-Lite registers
`timescale 1ns/1ps
module pt_timer
   import pt_pkg::*;
(
   // clock, reset, freeze
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // external clock and gate pins
   input wire logic lower_ext_clk,
   input wire logic upper_ext_clk,
   input wire logic lower_gate,
   input wire logic upper_gate,
   // processor idle level, same clock
   input wire logic cpu_idle,
   // interrupt
   output logic irq
);

   // ****************************************
   // declarations
   // ****************************************
   pt_bus_e state_q, state_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic addr_ph, wr_en, rd_en;

   logic [15:0] ctl_q [2];
   logic [15:0] ctl_d [2];
   logic [15:0] per_q [2];
   logic [15:0] per_d [2];
   logic [15:0] hold_q, hold_d;
   logic [31:0] cnt_q, cnt_d;
   logic [1:0] sts_q, sts_d;
   logic [1:0] msk_q, msk_d;
   logic [1:0] ev;

   logic [NPIN-1:0] pin_lvl;
   logic [1:0] prev_q, prev_d;
   logic [1:0] ext_rise;
   logic [1:0] tick;
   logic m32, hit_lo, hit_hi;
   logic [15:0] wd16;

   // ****************************************
   // pin synchronisers
   // ****************************************
   // count clocks and gates are asynchronous pins; logic sees them
   // only through the three-stage chain
   pt_sync u_sync (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .pin({upper_gate, lower_gate, upper_ext_clk, lower_ext_clk}),
      .level(pin_lvl)
   );

   // rising edges of the clean external clocks
   // prev_q resets low like an idle pin, so reset gives no false edge
   // only the clean level is compared, never a raw pin
   always_comb begin
      prev_d = pin_lvl[1:0];
      ext_rise = pin_lvl[1:0] & ~prev_q;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prev_q <= '0;
      end else if (ce) begin
         prev_q <= prev_d;
      end
   end

   // ****************************************
   // per-timer prescaler and tick
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_tmr
         logic [7:0] pre_q, pre_d;
         logic raw, run, src, rsync_q;
         logic [15:0] ctl;

         // each half uses its own control; upper one is unused when cascaded
         assign ctl = ctl_q[gi];

         // run qualifiers: enable, stop in idle, gate
         // stop in idle applies to the pin counter source only
         // gate only qualifies the internal cycle source
         always_comb begin
            run = ctl[CTL_ON] & ~(ctl[CTL_CS] & ctl[CTL_SIDL] & cpu_idle)
                  & (ctl[CTL_CS] | ~ctl[CTL_GATE] | pin_lvl[PIN_GATE0 + gi]);
            src = ctl[CTL_CS] ? ext_rise[gi] : 1'b1;
            pre_d = pre_q;
            raw = 1'b0;
            if (!ctl[CTL_ON]) begin
               pre_d = '0;
            end else if (run && src) begin
               if (pre_q >= pt_presc_max(ctl[CTL_PS_HI:CTL_PS_LO])) begin
                  pre_d = '0;
                  raw = 1'b1;
               end else begin
                  pre_d = pre_q + 8'h01;
               end
            end
         end

         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               pre_q <= '0;
               rsync_q <= 1'b0;
            end else if (ce) begin
               pre_q <= pre_d;
               rsync_q <= raw;
            end
         end

         // lower half resynchronises prescaler output, upper uses it directly
         // the extra flop costs one cycle of latency on lower ticks but
         // keeps a fast pin clock from racing the count compare
         if (gi == 0) begin : g_lo
            assign tick[gi] = rsync_q;
         end else begin : g_hi
            assign tick[gi] = raw;
         end
      end
   endgenerate

   // ****************************************
   // ahb-lite slave sequencing
   // ****************************************
   assign addr_ph = hsel & htrans[1] & hready;
   assign wr_en = (state_q == B_WRITE);
   assign rd_en = (state_q == B_READ);

   // address phase capture, one wait state on reads
   // the read wait state lets the returned low word and the holding
   // latch capture come from one and the same count value
   // writes need no wait: they land at the end of the data phase
   always_comb begin
      state_d = state_q;
      addr_d = addr_q;
      hrdata_d = hrdata_q;
      case (state_q)
         B_READ: begin
            state_d = B_RDATA;
            case (addr_q)
               OFF_LOW_CNT: hrdata_d = {16'h0000, cnt_q[15:0]};
               OFF_HIGH_CNT: hrdata_d = {16'h0000, cnt_q[31:16]};
               OFF_HOLD: hrdata_d = {16'h0000, hold_q};
               OFF_PER_LO: hrdata_d = {16'h0000, per_q[0]};
               OFF_PER_HI: hrdata_d = {16'h0000, per_q[1]};
               OFF_CTL_LO: hrdata_d = {16'h0000, ctl_q[0]};
               OFF_CTL_HI: hrdata_d = {16'h0000, ctl_q[1]};
               OFF_IRQ_STS: hrdata_d = {30'h00000000, sts_q};
               OFF_IRQ_MSK: hrdata_d = {30'h00000000, msk_q};
               default: hrdata_d = 32'h00000000;
            endcase
         end
         default: begin
            if (addr_ph) begin
               addr_d = haddr[ADDR_W-1:0];
               state_d = hwrite ? B_WRITE : B_READ;
            end else begin
               state_d = B_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= B_IDLE;
         addr_q <= '0;
         hrdata_q <= '0;
      end else if (ce) begin
         state_q <= state_d;
         addr_q <= addr_d;
         hrdata_q <= hrdata_d;
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = (state_q != B_READ);
   assign hresp = 1'b0;

   // ****************************************
   // count, period, control, interrupt
   // ****************************************
   assign m32 = ctl_q[0][CTL_T32];
   assign hit_lo = (cnt_q[15:0] == per_q[0]);
   assign hit_hi = (cnt_q[31:16] == per_q[1]);
   assign wd16 = hwdata[15:0];

   // next count: ticks first, bus writes override
   // cascaded mode uses only the lower tick; upper control, prescaler
   // and gate are left running but have no effect on the count
   // a count write in the same cycle as a tick wins, so software sees
   // exactly the value it wrote
   always_comb begin
      cnt_d = cnt_q;
      ev = 2'b00;
      if (m32) begin
         if (tick[0]) begin
            if (hit_lo && hit_hi) begin
               cnt_d = {CNT_RESET, CNT_RESET};
               ev[IRQ_UPPER] = 1'b1;
            end else begin
               cnt_d = cnt_q + 32'h00000001;
            end
         end
      end else begin
         if (tick[0]) begin
            if (hit_lo) begin
               cnt_d[15:0] = CNT_RESET;
               ev[IRQ_LOWER] = 1'b1;
            end else begin
               cnt_d[15:0] = cnt_q[15:0] + 16'h0001;
            end
         end
         if (tick[1]) begin
            if (hit_hi) begin
               cnt_d[31:16] = CNT_RESET;
               ev[IRQ_UPPER] = 1'b1;
            end else begin
               cnt_d[31:16] = cnt_q[31:16] + 16'h0001;
            end
         end
      end
      if (wr_en && addr_q == OFF_LOW_CNT) begin
         cnt_d[15:0] = wd16;
         if (m32) begin
            cnt_d[31:16] = hold_q;
         end
      end
      if (wr_en && addr_q == OFF_HIGH_CNT) begin
         cnt_d[31:16] = wd16;
      end
   end

   // register writes, holding latch capture, sticky status
   // status set is applied last so an event never loses against a
   // write-one-to-clear that lands in the same cycle
   always_comb begin
      ctl_d = ctl_q;
      per_d = per_q;
      hold_d = hold_q;
      msk_d = msk_q;
      sts_d = sts_q;
      if (rd_en && addr_q == OFF_LOW_CNT) begin
         hold_d = cnt_q[31:16];
      end
      if (wr_en) begin
         case (addr_q)
            OFF_HOLD: hold_d = wd16;
            OFF_PER_LO: per_d[0] = wd16;
            OFF_PER_HI: per_d[1] = wd16;
            OFF_CTL_LO: ctl_d[0] = wd16 & CTL_WMASK;
            OFF_CTL_HI: ctl_d[1] = wd16 & CTL_WMASK;
            OFF_IRQ_STS: sts_d = sts_q & ~hwdata[1:0];
            OFF_IRQ_MSK: msk_d = hwdata[1:0];
            default: hold_d = hold_d;
         endcase
      end
      sts_d = sts_d | ev; // set beats write-one-to-clear
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
         ctl_q[0] <= CTL_RESET;
         ctl_q[1] <= CTL_RESET;
         per_q[0] <= PER_RESET;
         per_q[1] <= PER_RESET;
         hold_q <= '0;
         sts_q <= '0;
         msk_q <= '0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         ctl_q <= ctl_d;
         per_q <= per_d;
         hold_q <= hold_d;
         sts_q <= sts_d;
         msk_q <= msk_d;
      end
   end

   // level interrupt from unmasked status
   // stays high until software clears the status bit or its mask
   assign irq = |(sts_q & msk_q);

endmodule : pt_timer

// File: verilog/pt_pkg.sv
// constants, field layout and types for the paired 16/32-bit timer
// Contract
// - cascaded count: lower is low word
// - cascaded mode ignores upper control register
// - cascaded timer uses lower clock and gate
// - cascaded interrupt via upper flag and enable
// - 32-bit period match raises interrupt request
// - split timers: timer or synchronous counter only
// - lower prescaler output resynchronised, upper not
// - timer mode counts cycles, wraps at period
// - counter mode counts synced edges, wraps
// - low word read latches high word
// - cascaded low word write loads high from latch
// - counter stops in idle when bit set
// - two 16-bit control registers select modes
package pt_pkg;

   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_LOW_CNT = 8'h00;
   localparam logic [7:0] OFF_HIGH_CNT = 8'h04;
   localparam logic [7:0] OFF_HOLD = 8'h08;
   localparam logic [7:0] OFF_PER_LO = 8'h0C;
   localparam logic [7:0] OFF_PER_HI = 8'h10;
   localparam logic [7:0] OFF_CTL_LO = 8'h14;
   localparam logic [7:0] OFF_CTL_HI = 8'h18;
   localparam logic [7:0] OFF_IRQ_STS = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h20;
   localparam int unsigned ADDR_W = 8;

   // ****************************************
   // control register fields
   // ****************************************
   localparam int unsigned CTL_ON = 15;
   localparam int unsigned CTL_SIDL = 13;
   localparam int unsigned CTL_GATE = 6;
   localparam int unsigned CTL_PS_HI = 5;
   localparam int unsigned CTL_PS_LO = 4;
   localparam int unsigned CTL_T32 = 3;
   localparam int unsigned CTL_CS = 1;
   localparam logic [15:0] CTL_WMASK = 16'hA07A;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] PER_RESET = 16'hFFFF;
   localparam logic [15:0] CNT_RESET = 16'h0000;

   // ****************************************
   // interrupt bits, pins, prescaler
   // ****************************************
   localparam int unsigned IRQ_LOWER = 0;
   localparam int unsigned IRQ_UPPER = 1;
   localparam int unsigned NPIN = 4;
   localparam int unsigned PIN_GATE0 = 2;
   localparam logic [7:0] PS_MAX_1 = 8'h00;
   localparam logic [7:0] PS_MAX_8 = 8'h07;
   localparam logic [7:0] PS_MAX_64 = 8'h3F;
   localparam logic [7:0] PS_MAX_256 = 8'hFF;

   // bus slave states
   typedef enum logic [1:0] {B_IDLE, B_WRITE, B_READ, B_RDATA} pt_bus_e;

   // last prescaler count before it emits a tick
   function automatic logic [7:0] pt_presc_max(input logic [1:0] sel);
      case (sel)
         2'h0: pt_presc_max = PS_MAX_1;
         2'h1: pt_presc_max = PS_MAX_8;
         2'h2: pt_presc_max = PS_MAX_64;
         default: pt_presc_max = PS_MAX_256;
      endcase
   endfunction : pt_presc_max

endpackage : pt_pkg

// File: verilog/pt_sync.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module pt_sync
   import pt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // pins in, clean levels out
   input wire logic [NPIN-1:0] pin,
   output logic [NPIN-1:0] level
);

   logic [NPIN-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [NPIN-1:0] lvl_d;

   // take stage two only where it matches stage three
   always_comb begin
      lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
   end

   // shift chain; first stage feeds only the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else if (ce) begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;

endmodule : pt_sync

// File: verification/pt_timer_props.sv
// checker of bus timing, read values and interrupt output of the timer pair
`timescale 1ns/1ps
module pt_timer_props
   import pt_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   // interrupt
   input wire logic irq
);
   // ****************************************
   // transfer tracking
   // ****************************************
   logic acc;
   logic rd_q, rd_d, rdd_q, rdd_d, wr_q, wr_d;
   logic [7:0] adr_q, adr_d;
   logic [1:0] msk_q, msk_d;

   assign acc = ce & hsel & htrans[1] & hready;

   // next state of the tracker
   always_comb begin
      rd_d = acc & ~hwrite;
      wr_d = acc & hwrite;
      rdd_d = rd_q;
      adr_d = acc ? haddr[7:0] : adr_q;
      msk_d = (wr_q && adr_q == OFF_IRQ_MSK) ? hwdata[1:0] : msk_q;
   end

   // tracker registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_q <= 1'b0;
         rdd_q <= 1'b0;
         wr_q <= 1'b0;
         adr_q <= 8'h00;
         msk_q <= 2'h0;
      end else begin
         rd_q <= rd_d;
         rdd_q <= rdd_d;
         wr_q <= wr_d;
         adr_q <= adr_d;
         msk_q <= msk_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   rd_wait_a: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   wr_nowait_a: assert property (acc && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   rdata_hold_a: assert property (hreadyout |=> $stable(hrdata))
      else $error("read data moved outside a read");
   word_width_a: assert property (rdd_q |-> hrdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   unmapped_zero_a: assert property (rdd_q && adr_q > OFF_IRQ_MSK |-> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   ctl_bits_a: assert property (rdd_q && (adr_q == OFF_CTL_LO || adr_q == OFF_CTL_HI)
      |-> (hrdata[15:0] & ~CTL_WMASK) == 16'h0000)
      else $error("unused control bits read back");
   irq_mask_a: assert property (msk_q == 2'h0 |-> !irq)
      else $error("interrupt with mask clear");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr_q))
      else $error("interrupt dropped without a write");
endmodule : pt_timer_props

bind pt_timer pt_timer_props i_props (.clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .irq(irq));

// File: verification/pt_ext_src.sv
// behavioural source of the external count clock pins
`timescale 1ns/1ps
module pt_ext_src (
   // timing reference
   input wire logic clk,
   // count clock pins
   output logic lower_ext_clk,
   output logic upper_ext_clk
);
   // pins rest low between bursts
   initial begin
      lower_ext_clk = 1'b0;
      upper_ext_clk = 1'b0;
   end

   // n rising edges, each level held hc cycles
   task automatic pulse(input int n, input int hc, input logic up);
      for (int i = 0; i < n; i++) begin
         repeat (hc) @(posedge clk);
         if (up) upper_ext_clk <= 1'b1;
         else lower_ext_clk <= 1'b1;
         repeat (hc) @(posedge clk);
         upper_ext_clk <= 1'b0;
         lower_ext_clk <= 1'b0;
      end
   endtask : pulse
endmodule : pt_ext_src

// File: verification/paired_timer_32bit_tb.sv
// self-checking testbench of the paired timer block
`timescale 1ns/1ps
module paired_timer_32bit_tb
   import pt_pkg::*;
;
   logic clk, rstn, ce, hsel, hwrite, cpu_idle, hreadyout, hresp, irq, lo_ext, up_ext, lo_gate, up_gate;
   logic [31:0] haddr, hwdata, hrdata, rdat, r0;
   logic [1:0] htrans;
   int num_errors, compares;

   // clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   pt_timer i_pt_timer (.clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .lower_ext_clk(lo_ext), .upper_ext_clk(up_ext),
      .lower_gate(lo_gate), .upper_gate(up_gate), .cpu_idle(cpu_idle), .irq(irq));
   pt_ext_src ext (.clk(clk), .lower_ext_clk(lo_ext), .upper_ext_clk(up_ext));

   // ****************************************
   // helpers
   // ****************************************
   task automatic finish_test();
      $display("compares %0d, num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   // wait for hready high, then pass its edge
   task automatic rdy();
      int n;
      n = 0;
      @(negedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            num_errors++;
            finish_test();
         end
         @(negedge clk);
      end
      rdat = hrdata;
      @(posedge clk);
   endtask : rdy

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      rdy();
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), exp, rdat);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : rd

   task automatic ci(input logic exp);
      @(negedge clk);
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask : ci

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      logic [7:0] offs [9] = '{OFF_LOW_CNT, OFF_HIGH_CNT, OFF_HOLD, OFF_PER_LO, OFF_PER_HI, OFF_CTL_LO,
         OFF_CTL_HI, OFF_IRQ_STS, OFF_IRQ_MSK};
      for (int i = 0; i < 9; i++) rd(offs[i], (i == 3 || i == 4) ? 32'hFFFF : 32'h0);
      wr(8'h24, 32'hFFFF);
      rd(8'h24, 32'h0);
      wr(OFF_CTL_HI, 32'hFFFF);
      rd(OFF_CTL_HI, {16'h0, CTL_WMASK});
      wr(OFF_CTL_HI, 32'h0);
   endtask : t_reset

   task automatic t_counter();
      wr(OFF_PER_LO, 32'h6);
      wr(OFF_CTL_LO, 32'h8002);
      ext.pulse(5, 4, 1'b0);
      repeat (12) @(posedge clk);
      rd(OFF_LOW_CNT, 32'h5);
      cpu_idle <= 1'b1;
      wr(OFF_CTL_LO, 32'hA002);
      ext.pulse(3, 4, 1'b0);
      repeat (12) @(posedge clk);
      rd(OFF_LOW_CNT, 32'h5);
      cpu_idle <= 1'b0;
      ext.pulse(3, 4, 1'b0);
      repeat (12) @(posedge clk);
      rd(OFF_LOW_CNT, 32'h1);
      rd(OFF_IRQ_STS, 32'h1);
      wr(OFF_CTL_HI, 32'h8002);
      ext.pulse(2, 4, 1'b1);
      repeat (12) @(posedge clk);
      rd(OFF_HIGH_CNT, 32'h2);
      wr(OFF_CTL_LO, 32'h0);
      wr(OFF_CTL_HI, 32'h0);
      wr(OFF_IRQ_STS, 32'h3);
      rd(OFF_IRQ_STS, 32'h0);
   endtask : t_counter

   task automatic t_cascade();
      int n;
      wr(OFF_PER_LO, 32'h4);
      wr(OFF_PER_HI, 32'h2);
      wr(OFF_CTL_LO, 32'h0008);
      wr(OFF_CTL_HI, 32'h8000);
      wr(OFF_HOLD, 32'h1);
      wr(OFF_LOW_CNT, 32'hFFFC);
      rd(OFF_HIGH_CNT, 32'h1);
      wr(OFF_HOLD, 32'h0);
      rd(OFF_LOW_CNT, 32'hFFFC);
      rd(OFF_HOLD, 32'h1);
      wr(OFF_IRQ_MSK, 32'h2);
      wr(OFF_CTL_LO, 32'h8008);
      n = 0;
      while (irq !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 200) begin
            num_errors++;
            finish_test();
         end
      end
      rd(OFF_IRQ_STS, 32'h2);
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      r0 = rdat;
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      chk("count step", 32'h4, rdat - r0);
      chk("wrapped", 32'h1, {31'h0, rdat < 32'h40});
      r0 = rdat;
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      chk("frozen step", 32'h4, rdat - r0);
      wr(OFF_CTL_LO, 32'h8048);
      up_gate <= 1'b1;
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      r0 = rdat;
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      chk("gated step", 32'h0, rdat - r0);
      lo_gate <= 1'b1;
      repeat (8) @(posedge clk);
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      r0 = rdat;
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      chk("gate open step", 32'h4, rdat - r0);
      wr(OFF_CTL_LO, 32'h8058);
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      r0 = rdat;
      repeat (28) @(posedge clk);
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      chk("prescaled step", 32'h4, rdat - r0);
      rd(OFF_HOLD, 32'h0);
      wr(OFF_IRQ_MSK, 32'h0);
      ci(1'b0);
      wr(OFF_IRQ_MSK, 32'h2);
      ci(1'b1);
      wr(OFF_CTL_LO, 32'h0008);
      wr(OFF_IRQ_STS, 32'h2);
      ci(1'b0);
      wr(OFF_CTL_HI, 32'h0);
      wr(OFF_PER_LO, 32'h100);
      wr(OFF_LOW_CNT, 32'h0);
      wr(OFF_CTL_LO, 32'h8000);
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      r0 = rdat;
      bus(1'b0, OFF_LOW_CNT, 32'h0);
      chk("split step", 32'h4, rdat - r0);
   endtask : t_cascade

   // main sequence
   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      cpu_idle = 1'b0;
      ce = 1'b1;
      lo_gate = 1'b0;
      up_gate = 1'b0;
      num_errors = 0;
      compares = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_counter();
      t_cascade();
      finish_test();
   end
endmodule : paired_timer_32bit_tb
